// [core/cbu_pkg.sv]
// shared types and constants for the conditional branch unit
package cbu_pkg;

	// program counter width in bits
	localparam int PC_W       = 16;
	// signed offset width of the relative branch
	localparam int OFS_W      = 7;
	// pc value after reset
	localparam logic [15:0] PC_RESET = 16'h0000;
	// cycles spent by a branch that is not taken / taken
	localparam int CYC_NOT_TAKEN = 1;
	localparam int CYC_TAKEN     = 2;

	// branch selector, one code per conditional opcode
	typedef enum logic [3:0] {
		CBU_NONE,
		CBU_BRANCH_NOT_EQUAL_OP,
		CBU_BRANCH_CARRY_SET_OP,
		CBU_BRANCH_CARRY_CLEAR_OP,
		CBU_BRANCH_SAME_HIGHER_OP,
		CBU_BRANCH_LOWER_OP,
		CBU_BRANCH_MINUS_OP,
		CBU_BRANCH_PLUS_OP,
		CBU_BRANCH_GE_SIGNED_OP,
		CBU_BRANCH_LT_SIGNED_OP
	} cbu_op_t;

	// status flags consulted by the branches
	typedef struct packed {
		logic zero;
		logic carry;
		logic negative;
		logic overflow;
	} cbu_flags_t;

	// one issued branch request
	typedef struct packed {
		logic       valid;
		cbu_op_t    op;
		logic [6:0] offset;
	} cbu_req_t;

	// sequencer states
	typedef enum logic [0:0] {
		CBU_IDLE,
		CBU_SECOND
	} cbu_state_t;

endpackage

// [core/cbu_cond_eval.sv]
// combinational flag test for one conditional branch opcode
`timescale 1ns/1ps
module cbu_cond_eval
(
	// request
	input  wire cbu_pkg::cbu_op_t    op,
	input  wire cbu_pkg::cbu_flags_t flags,
	// verdict
	output logic                     take
);

	////////////////////////////////////////////////////////////////
	// one condition per opcode; unknown opcodes never branch
	always_comb
	begin
		case (op)
			cbu_pkg::CBU_BRANCH_NOT_EQUAL_OP:   take = ~flags.zero;
			cbu_pkg::CBU_BRANCH_CARRY_SET_OP:   take = flags.carry;
			cbu_pkg::CBU_BRANCH_CARRY_CLEAR_OP: take = ~flags.carry;
			cbu_pkg::CBU_BRANCH_SAME_HIGHER_OP: take = ~flags.carry;
			cbu_pkg::CBU_BRANCH_LOWER_OP:       take = flags.carry;
			cbu_pkg::CBU_BRANCH_MINUS_OP:       take = flags.negative;
			cbu_pkg::CBU_BRANCH_PLUS_OP:        take = ~flags.negative;
			cbu_pkg::CBU_BRANCH_GE_SIGNED_OP:   take = ~(flags.negative ^ flags.overflow);
			cbu_pkg::CBU_BRANCH_LT_SIGNED_OP:   take = flags.negative ^ flags.overflow;
			default:                            take = 1'b0;
		endcase
	end

endmodule

// [core/cbu_branch_unit.sv]
// conditional relative branch unit: condition test, target and cycle count
`timescale 1ns/1ps
module cbu_branch_unit
#(
	parameter int PC_W  = cbu_pkg::PC_W,
	parameter int OFS_W = cbu_pkg::OFS_W
)
(
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	// issued instruction
	input  wire cbu_pkg::cbu_req_t    req,
	input  wire cbu_pkg::cbu_flags_t  flags_in,
	// program counter
	output logic [PC_W-1:0]           pc_out,
	// status flags after the instruction
	output cbu_pkg::cbu_flags_t       flags_out,
	// sequencing
	output logic                      busy_out,
	output logic                      done_out,
	output logic                      taken_out
);

	////////////////////////////////////////////////////////////////
	// elaboration checks: the packed request and state types fix both widths,
	// so any other value would silently truncate the target sum
	if (PC_W != 16 || OFS_W != 7)
	begin : g_bad_width
		$error("cbu_branch_unit: package types fix pc at 16 and offset at 7 bits");
	end

	////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		cbu_pkg::cbu_state_t st;      // sequencer
		logic [15:0]         pc;      // program counter
		cbu_pkg::cbu_flags_t flags;   // status copy
		logic                busy;    // second cycle of a taken branch
		logic                done;    // instruction finished this cycle
		logic                taken;   // last branch went
	} cbu_regs_t;

	cbu_regs_t r_q;                   // registered state
	cbu_regs_t r_d;                   // next state
	logic      take;                  // verdict of the flag test
	logic      accept;                // a request is taken this cycle

	////////////////////////////////////////////////////////////////
	// flag test
	cbu_cond_eval i_cbu_cond_eval
	(
		.op    (req.op),
		.flags (flags_in),
		.take  (take)
	);

	// requests are only accepted while not finishing a taken branch
	// a request in the busy cycle is dropped, not queued: the issuer must retry
	assign accept = req.valid && (r_q.st == cbu_pkg::CBU_IDLE);

	////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		r_d       = r_q;
		r_d.done  = 1'b0;
		r_d.flags = flags_in;  // branches pass flags through untouched
		case (r_q.st)
			cbu_pkg::CBU_IDLE:
			begin
				if (accept)
				begin
					r_d.taken = take;
					if (take)
					begin
						// target is pc + signed offset + 1, wraps within pc width
						r_d.pc   = r_q.pc + {{9{req.offset[6]}}, req.offset} + 16'h0001;
						r_d.st   = cbu_pkg::CBU_SECOND;  // extra cycle for the refetch
						r_d.busy = 1'b1;
					end
					else
					begin
						r_d.pc   = r_q.pc + 16'h0001;   // fall through in one cycle
						r_d.done = 1'b1;
					end
				end
			end
			cbu_pkg::CBU_SECOND:
			begin
				r_d.st   = cbu_pkg::CBU_IDLE;
				r_d.busy = 1'b0;
				r_d.done = 1'b1;
			end
			// unreachable with two states; falls back to idle if ever hit
			default:
				r_d.st = cbu_pkg::CBU_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// register
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			r_q.st    <= cbu_pkg::CBU_IDLE;
			r_q.pc    <= cbu_pkg::PC_RESET;
			r_q.flags <= '0;
			r_q.busy  <= 1'b0;
			r_q.done  <= 1'b0;
			r_q.taken <= 1'b0;
		end
		else
			r_q <= r_d;
	end

	// outputs straight from flops
	assign pc_out    = r_q.pc;
	assign flags_out = r_q.flags;
	assign busy_out  = r_q.busy;
	assign done_out  = r_q.done;
	assign taken_out = r_q.taken;

	////////////////////////////////////////////////////////////////
	// checks
	sequence s_taken_issue;
		req.valid && !busy_out && take;
	endsequence

	sequence s_untaken_issue;
		req.valid && !busy_out && !take;
	endsequence

	chk_taken_target: assert property (@(posedge ref_clk) disable iff (reset)
		s_taken_issue |=> pc_out == $past(pc_out) + {{9{$past(req.offset[6])}}, $past(req.offset)} + 16'h0001)
		else $error("taken branch target wrong");

	chk_taken_two: assert property (@(posedge ref_clk) disable iff (reset)
		s_taken_issue |=> busy_out && !done_out ##1 done_out && !busy_out)
		else $error("taken branch not two cycles");

	chk_untaken_one: assert property (@(posedge ref_clk) disable iff (reset)
		s_untaken_issue |=> done_out && !busy_out && pc_out == $past(pc_out) + 16'h0001)
		else $error("untaken branch not one cycle");

	chk_flags_kept: assert property (@(posedge ref_clk) disable iff (reset)
		1'b1 |=> flags_out == $past(flags_in))
		else $error("flags altered by branch");

	chk_carry_set: assert property (@(posedge ref_clk) disable iff (reset)
		req.valid && !busy_out && req.op == cbu_pkg::CBU_BRANCH_CARRY_SET_OP |=> taken_out == $past(flags_in.carry))
		else $error("carry set branch decision wrong");

	chk_carry_clear: assert property (@(posedge ref_clk) disable iff (reset)
		req.valid && !busy_out && (req.op == cbu_pkg::CBU_BRANCH_CARRY_CLEAR_OP ||
		req.op == cbu_pkg::CBU_BRANCH_SAME_HIGHER_OP) |=> taken_out == !$past(flags_in.carry))
		else $error("carry clear branch decision wrong");

	chk_lower: assert property (@(posedge ref_clk) disable iff (reset)
		req.valid && !busy_out && req.op == cbu_pkg::CBU_BRANCH_LOWER_OP |=> taken_out == $past(flags_in.carry))
		else $error("lower branch decision wrong");

	chk_sign_minus: assert property (@(posedge ref_clk) disable iff (reset)
		req.valid && !busy_out && req.op == cbu_pkg::CBU_BRANCH_MINUS_OP |=> taken_out == $past(flags_in.negative))
		else $error("minus branch decision wrong");

	chk_sign_plus: assert property (@(posedge ref_clk) disable iff (reset)
		req.valid && !busy_out && req.op == cbu_pkg::CBU_BRANCH_PLUS_OP |=> taken_out == !$past(flags_in.negative))
		else $error("plus branch decision wrong");

	chk_signed_ge: assert property (@(posedge ref_clk) disable iff (reset)
		req.valid && !busy_out && req.op == cbu_pkg::CBU_BRANCH_GE_SIGNED_OP
		|=> taken_out == !($past(flags_in.negative) ^ $past(flags_in.overflow)))
		else $error("signed ge decision wrong");

	chk_signed_lt: assert property (@(posedge ref_clk) disable iff (reset)
		req.valid && !busy_out && req.op == cbu_pkg::CBU_BRANCH_LT_SIGNED_OP
		|=> taken_out == ($past(flags_in.negative) ^ $past(flags_in.overflow)))
		else $error("signed lt decision wrong");

	chk_not_equal: assert property (@(posedge ref_clk) disable iff (reset)
		req.valid && !busy_out && req.op == cbu_pkg::CBU_BRANCH_NOT_EQUAL_OP |=> taken_out == !$past(flags_in.zero))
		else $error("not equal decision wrong");

	// a request that arrives during the busy cycle must leave no trace
	sequence s_refused_issue;
		req.valid && busy_out;
	endsequence

	chk_refused_busy: assert property (@(posedge ref_clk) disable iff (reset)
		s_refused_issue |=> !busy_out && pc_out == $past(pc_out) && taken_out == $past(taken_out))
		else $error("request accepted while busy");

	// same-or-higher shares the carry-clear test but has its own opcode
	chk_same_higher: assert property (@(posedge ref_clk) disable iff (reset)
		req.valid && !busy_out && req.op == cbu_pkg::CBU_BRANCH_SAME_HIGHER_OP
		|=> taken_out == !$past(flags_in.carry))
		else $error("same or higher decision wrong");

	// the busy cycle always ends the branch on the next edge
	chk_busy_done: assert property (@(posedge ref_clk) disable iff (reset)
		busy_out |=> done_out && !busy_out)
		else $error("taken branch did not finish after busy cycle");

	// without a request the pc and the decision stand still
	chk_idle_hold: assert property (@(posedge ref_clk) disable iff (reset)
		!req.valid && !busy_out
		|=> !done_out && !busy_out && pc_out == $past(pc_out) && taken_out == $past(taken_out))
		else $error("unit moved without a request");

endmodule

// [verif/cbu_branch_unit_test.sv]
// self-checking bench for the conditional branch unit
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t %h %h", $time, g, e); end end
module cbu_branch_unit_test;
	// one expected completion
	typedef struct {logic [15:0] pc; logic tk; cbu_pkg::cbu_flags_t fl; int cyc;} cbu_note_t;

	logic                ref_clk   = 1'b0; // core clock
	logic                reset     = 1'b1; // sync reset
	cbu_pkg::cbu_req_t   req       = '0;   // issued branch
	cbu_pkg::cbu_flags_t flags_in  = '0;   // flags fed in
	logic [15:0]         pc_out;           // pc seen
	cbu_pkg::cbu_flags_t flags_out;        // flags seen
	logic                busy_out;         // second cycle
	logic                done_out;         // completion pulse
	logic                taken_out;        // last decision
	int                  n_fail    = 0;    // mismatches
	int                  tests_run = 0;    // comparisons
	int                  cyc       = 0;    // cycle count
	int                  seed      = 53;   // fixed seed
	logic [15:0]         pc_m      = cbu_pkg::PC_RESET; // model pc
	cbu_note_t           q[$];             // pending notes
	cbu_note_t           nt;               // note under check

	////////////////////////////////////////////////////////////////
	// clock, device
	always #2.5 ref_clk = ~ref_clk;

	cbu_branch_unit i_cbu_branch_unit
	(
		.ref_clk   (ref_clk),
		.reset     (reset),
		.req       (req),
		.flags_in  (flags_in),
		.pc_out    (pc_out),
		.flags_out (flags_out),
		.busy_out  (busy_out),
		.done_out  (done_out),
		.taken_out (taken_out)
	);

	////////////////////////////////////////////////////////////////
	// own reading of each branch condition
	function automatic logic cond(cbu_pkg::cbu_op_t op, cbu_pkg::cbu_flags_t f);
		case (op)
			cbu_pkg::CBU_BRANCH_NOT_EQUAL_OP:   return !f.zero;
			cbu_pkg::CBU_BRANCH_CARRY_SET_OP:   return f.carry;
			cbu_pkg::CBU_BRANCH_CARRY_CLEAR_OP: return !f.carry;
			cbu_pkg::CBU_BRANCH_SAME_HIGHER_OP: return !f.carry;
			cbu_pkg::CBU_BRANCH_LOWER_OP:       return f.carry;
			cbu_pkg::CBU_BRANCH_MINUS_OP:       return f.negative;
			cbu_pkg::CBU_BRANCH_PLUS_OP:        return !f.negative;
			cbu_pkg::CBU_BRANCH_GE_SIGNED_OP:   return !(f.negative ^ f.overflow);
			cbu_pkg::CBU_BRANCH_LT_SIGNED_OP:   return f.negative ^ f.overflow;
			default:                            return 1'b0;
		endcase
	endfunction

	// drive one branch and note what must come out
	task automatic issue(cbu_pkg::cbu_op_t op, logic [6:0] ofs, cbu_pkg::cbu_flags_t f);
		logic tk;
		tk = cond(op, f);
		req = '{1'b1, op, ofs};
		flags_in = f;
		pc_m = tk ? pc_m + {{9{ofs[6]}}, ofs} + 16'h0001 : pc_m + 16'h0001;
		q.push_back('{pc_m, tk, f, cyc});
		@(posedge ref_clk);
		#1;
		`CHK(busy_out, tk)
		// taken: request left up through the busy cycle, must be ignored
		if (tk)
		begin
			@(posedge ref_clk);
			#1;
		end
	endtask

	// go idle and let every pending completion land
	task automatic flush(string name);
		req.valid = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		`CHK(q.size(), 0)
		$display("test %s finished", name);
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// monitor: each done pulse retires the oldest note
	always @(negedge ref_clk)
	begin
		if (!reset && done_out === 1'b1)
		begin
			if (q.size() == 0)
			begin
				n_fail++;
				$display("[ERR] %0t %h %h", $time, done_out, 1'b0);
			end
			else
			begin
				nt = q.pop_front();
				`CHK(pc_out, nt.pc)
				`CHK(taken_out, nt.tk)
				`CHK(cyc - nt.cyc, nt.tk ? cbu_pkg::CYC_TAKEN : cbu_pkg::CYC_NOT_TAKEN)
				`CHK(busy_out, 1'b0)
				`CHK(flags_out, nt.fl)
			end
		end
	end

	// hang guard, well above the roughly 700 cycles needed
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_fail++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (2) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		`CHK({pc_out, flags_out, busy_out, done_out, taken_out}, {cbu_pkg::PC_RESET, 7'h00})
		// every opcode against every flag mix, back to back
		for (int o = 0; o < 10; o++)
			for (int f = 0; f < 16; f++)
				issue(cbu_pkg::cbu_op_t'(o), 7'($random(seed)), 4'(f));
		flush("sweep");
		// offset extremes, carry set so the jump is taken
		issue(cbu_pkg::CBU_BRANCH_CARRY_SET_OP, 7'h3f, 4'h4);
		issue(cbu_pkg::CBU_BRANCH_CARRY_SET_OP, 7'h40, 4'h4);
		issue(cbu_pkg::CBU_BRANCH_CARRY_SET_OP, 7'h7f, 4'h4);
		issue(cbu_pkg::CBU_BRANCH_CARRY_SET_OP, 7'h00, 4'h4);
		flush("offsets");
		// mid-run reset while idle: every output back to its reset value
		reset = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK({pc_out, flags_out, busy_out, done_out, taken_out}, {cbu_pkg::PC_RESET, 7'h00})
		reset = 1'b0;
		pc_m = cbu_pkg::PC_RESET;
		$display("test reset finished");
		// random mix
		repeat (300)
			issue(cbu_pkg::cbu_op_t'($unsigned($random(seed)) % 10), 7'($random(seed)), 4'($random(seed)));
		flush("random");
		test_done();
	end
endmodule
